//--- stepper_pkg.sv
// constants and types shared by the stepper phase sequencer
package stepper_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_POSITION = 8'h08;

  // status and mask bit positions
  localparam int BIT_OVERTEMP = 0;
  localparam int BIT_OVERCURRENT = 1;
  localparam int BIT_HOME = 2;
  localparam int STATUS_W = 3;

  // position register field positions
  localparam int POS_INDEX_LSB = 0;
  localparam int POS_MODE_LSB = 8;
  localparam int POS_HOLD_BIT = 12;
  localparam int POS_STANDBY_BIT = 13;
  localparam int POS_FAULT_BIT = 14;
  localparam int POS_PIN_BIT = 15;

  // angle index: 128 microsteps per electrical cycle, 32 per quadrant
  localparam int ANGLE_W = 7;
  localparam logic [ANGLE_W-1:0] ANGLE_HOME = 7'h10;
  localparam logic [ANGLE_W-1:0] ANGLE_QUARTER = 7'h20;

  // resolution select codes, sel_0 is the most significant bit
  localparam logic [2:0] MODE_STANDBY = 3'h0;
  localparam logic [2:0] MODE_FULL = 3'h1;
  localparam logic [2:0] MODE_HALF_A = 3'h2;
  localparam logic [2:0] MODE_QUARTER = 3'h3;
  localparam logic [2:0] MODE_HALF_B = 3'h4;
  localparam logic [2:0] MODE_EIGHTH = 3'h5;
  localparam logic [2:0] MODE_SIXTEENTH = 3'h6;
  localparam logic [2:0] MODE_THIRTYSECOND = 3'h7;

  // index increments per step, per resolution
  localparam logic [ANGLE_W-1:0] STEP_FULL = 7'h20;
  localparam logic [ANGLE_W-1:0] STEP_HALF = 7'h10;
  localparam logic [ANGLE_W-1:0] STEP_QUARTER = 7'h08;
  localparam logic [ANGLE_W-1:0] STEP_EIGHTH = 7'h04;
  localparam logic [ANGLE_W-1:0] STEP_SIXTEENTH = 7'h02;
  localparam logic [ANGLE_W-1:0] STEP_THIRTYSECOND = 7'h01;

  // current levels in percent
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] PCT_ZERO = 7'h00;

  // reset values
  localparam logic [STATUS_W-1:0] STATUS_RESET = 3'h0;
  localparam logic [STATUS_W-1:0] MASK_RESET = 3'h0;

  // drive command of one phase bridge
  typedef struct packed {
    logic drive_en;
    logic polarity;
    logic [6:0] level_pct;
  } phase_drive_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage

//--- stepper_phase_sequencer.sv
// stepper phase sequencer: angle index, phase currents, fault flag, registers
// What this block does
// - clockwise makes phase A lead by 90 degrees
// - counter-clockwise makes phase B lead by 90
// - decode resolution select into six step sizes
// - select 000 is standby, outputs off, full step
// - angle reset forces angle to home, otherwise step normally
// - home monitor low while angle held in reset
// - home is 45 degrees, 100 or 71 percent
// - fault pin pulled low on thermal or overcurrent
// - fault pin released when no fault present
// - one step per step clock rise only
// - output enable low turns all phase outputs off
`timescale 1ns/1ps
`default_nettype none

module stepper_phase_sequencer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic step_clk,
  input wire logic direction_select,
  input wire logic output_enable,
  input wire logic angle_reset,
  input wire logic step_res_sel_0,
  input wire logic step_res_sel_1,
  input wire logic step_res_sel_2,
  input wire logic overtemp_shutdown,
  input wire logic overcurrent_shutdown,
  output stepper_pkg::phase_drive_t phase_a_output,
  output stepper_pkg::phase_drive_t phase_b_output,
  output logic chopper_oscillator,
  output logic angle_home_monitor,
  input wire logic fault_flag_pin_i,
  output logic fault_flag_pin_o,
  output logic fault_flag_pin_oe_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  import stepper_pkg::*;

  // step size per resolution code
  function automatic logic [ANGLE_W-1:0] step_size(input logic [2:0] mode);
    logic [ANGLE_W-1:0] s;
    s = STEP_FULL;
    case (mode)
      MODE_STANDBY: s = STEP_FULL;
      MODE_FULL: s = STEP_FULL;
      MODE_HALF_A: s = STEP_HALF;
      MODE_QUARTER: s = STEP_QUARTER;
      MODE_HALF_B: s = STEP_HALF;
      MODE_EIGHTH: s = STEP_EIGHTH;
      MODE_SIXTEENTH: s = STEP_SIXTEENTH;
      MODE_THIRTYSECOND: s = STEP_THIRTYSECOND;
      default: s = STEP_FULL;
    endcase
    return s;
  endfunction

  // quarter-wave sine in percent, k from 0 to 32 covers 0 to 90 degrees
  function automatic logic [6:0] sine_pct(input logic [5:0] k);
    logic [6:0] p;
    p = PCT_ZERO;
    case (k)
      6'h00: p = 7'd0;
      6'h01: p = 7'd5;
      6'h02: p = 7'd10;
      6'h03: p = 7'd15;
      6'h04: p = 7'd20;
      6'h05: p = 7'd24;
      6'h06: p = 7'd29;
      6'h07: p = 7'd34;
      6'h08: p = 7'd38;
      6'h09: p = 7'd43;
      6'h0a: p = 7'd47;
      6'h0b: p = 7'd51;
      6'h0c: p = 7'd56;
      6'h0d: p = 7'd60;
      6'h0e: p = 7'd63;
      6'h0f: p = 7'd67;
      6'h10: p = 7'd71;
      6'h11: p = 7'd74;
      6'h12: p = 7'd77;
      6'h13: p = 7'd80;
      6'h14: p = 7'd83;
      6'h15: p = 7'd86;
      6'h16: p = 7'd88;
      6'h17: p = 7'd90;
      6'h18: p = 7'd92;
      6'h19: p = 7'd94;
      6'h1a: p = 7'd96;
      6'h1b: p = 7'd97;
      6'h1c: p = 7'd98;
      6'h1d: p = 7'd99;
      6'h1e: p = 7'd100;
      6'h1f: p = 7'd100;
      6'h20: p = 7'd100;
      default: p = PCT_ZERO;
    endcase
    return p;
  endfunction

  // signed sine of an angle index; coarse modes square any nonzero level to 100
  function automatic phase_drive_t phase_level(input logic [ANGLE_W-1:0] ang,
                                               input logic coarse);
    phase_drive_t d;
    logic [5:0] k;
    logic [6:0] mag;
    d = '0;
    k = {1'b0, ang[4:0]};
    // second quarter of each half cycle mirrors the table
    if (ang[5]) begin
      k = 6'h20 - {1'b0, ang[4:0]};
    end
    mag = sine_pct(k);
    if (coarse && (mag != PCT_ZERO)) begin
      mag = PCT_FULL;
    end
    d.drive_en = 1'b1;
    d.polarity = ~ang[6];
    d.level_pct = mag;
    return d;
  endfunction

  // registers
  logic step_clk_q;
  logic [ANGLE_W-1:0] angle_q;
  logic [ANGLE_W-1:0] angle_d;
  phase_drive_t phase_a_q;
  phase_drive_t phase_b_q;
  logic osc_en_q;
  logic home_mon_q;
  logic fault_q;
  logic [STATUS_W-1:0] status_q;
  logic [STATUS_W-1:0] status_d;
  logic [STATUS_W-1:0] mask_q;
  logic [31:0] rdata_q;
  logic home_was_q;

  // decode of the pins
  reg_req_t req;
  logic [2:0] mode;
  logic standby;
  logic coarse;
  logic step_rise;
  logic fault_now;
  logic at_home;
  logic outputs_on;
  phase_drive_t a_next;
  phase_drive_t b_next;
  logic [ANGLE_W-1:0] step_inc;

  // register port bundled once for decode
  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
  // mode pins are used live, so the host changes them only at home
  assign mode = {step_res_sel_0, step_res_sel_1, step_res_sel_2};
  assign standby = (mode == MODE_STANDBY);
  // standby keeps full step, so it is a coarse mode too
  assign coarse = (mode == MODE_STANDBY) || (mode == MODE_FULL) ||
                  (mode == MODE_HALF_A) || (mode == MODE_HALF_B);
  assign step_inc = step_size(mode);

  // one pulse per rising step clock, falling edges ignored
  assign step_rise = step_clk & ~step_clk_q;
  // either shutdown source counts as a fault
  assign fault_now = overtemp_shutdown | overcurrent_shutdown;
  // initial position, seen by the home monitor and the home event
  assign at_home = (angle_q == ANGLE_HOME);
  // shutdown also forces the bridges off, not only the flag
  assign outputs_on = output_enable & ~standby & ~fault_now;

  // next angle: home on reset, step up for cw, down for ccw, wrap natural
  always_comb begin
    angle_d = angle_q;
    if (angle_reset) begin
      angle_d = ANGLE_HOME;
    end else if (step_rise) begin
      if (direction_select) begin
        angle_d = angle_q + step_inc;
      end else begin
        angle_d = angle_q - step_inc;
      end
    end
  end

  // phase a sits a quarter cycle ahead of b in index space
  always_comb begin
    a_next = phase_level(angle_q + ANGLE_QUARTER, coarse);
    b_next = phase_level(angle_q, coarse);
    if (!outputs_on) begin
      a_next = '0;
      b_next = '0;
    end
  end

  // step edge detector; idles low like the pin, so reset makes no false rise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_clk_q <= 1'b0;
    end else begin
      step_clk_q <= step_clk;
    end
  end

  // angle index, parked at home out of reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      angle_q <= ANGLE_HOME;
    end else begin
      angle_q <= angle_d;
    end
  end

  // registered phase drive, one edge behind the index
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_a_q <= '0;
      phase_b_q <= '0;
    end else begin
      phase_a_q <= a_next;
      phase_b_q <= b_next;
    end
  end

  // oscillator run and home monitor
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_en_q <= 1'b0;
      home_mon_q <= 1'b0;
    end else begin
      osc_en_q <= ~standby;
      home_mon_q <= ~(angle_reset | at_home);
    end
  end

  // fault follows the shutdown level; no latch, the flag clears by itself
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_now;
    end
  end

  // events: sticky status, set wins over write-one-to-clear
  logic wr_status;
  logic wr_mask;
  logic [STATUS_W-1:0] events;
  assign wr_status = req.wr && (req.addr == ADDR_STATUS);
  assign wr_mask = req.wr && (req.addr == ADDR_MASK);
  assign events[BIT_OVERTEMP] = overtemp_shutdown;
  assign events[BIT_OVERCURRENT] = overcurrent_shutdown;
  assign events[BIT_HOME] = at_home & ~home_was_q & ~angle_reset;

  // clear first, then or in events, so a set in the same cycle wins
  always_comb begin
    status_d = status_q;
    if (wr_status) begin
      status_d = status_q & ~req.wdata[STATUS_W-1:0];
    end
    status_d = status_d | events;
  end

  // sticky status
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // mask, written as a whole
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= MASK_RESET;
    end else if (wr_mask) begin
      mask_q <= req.wdata[STATUS_W-1:0];
    end
  end

  // previous home flag; starts set so leaving reset at home is no event
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      home_was_q <= 1'b1;
    end else begin
      home_was_q <= at_home;
    end
  end

  // read mux, unmapped addresses read zero
  logic [31:0] pos_word;
  logic [31:0] rd_mux;
  always_comb begin
    pos_word = 32'h0000_0000;
    pos_word[POS_INDEX_LSB +: ANGLE_W] = angle_q;
    pos_word[POS_MODE_LSB +: 3] = mode;
    pos_word[POS_HOLD_BIT] = angle_reset;
    pos_word[POS_STANDBY_BIT] = standby;
    pos_word[POS_FAULT_BIT] = fault_q;
    pos_word[POS_PIN_BIT] = fault_flag_pin_i;
    rd_mux = 32'h0000_0000;
    case (req.addr)
      ADDR_STATUS: rd_mux[STATUS_W-1:0] = status_q;
      ADDR_MASK: rd_mux[STATUS_W-1:0] = mask_q;
      ADDR_POSITION: rd_mux = pos_word;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (req.rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // data outputs come straight from flip-flops
  assign phase_a_output = phase_a_q;
  assign phase_b_output = phase_b_q;
  assign chopper_oscillator = osc_en_q;
  assign angle_home_monitor = home_mon_q;

  // open drain: drive low only on fault, otherwise let the pull-up win
  assign fault_flag_pin_o = 1'b0;
  assign fault_flag_pin_oe_n = ~fault_q;
  assign reg_rdata = rdata_q;
  // level interrupt from flip-flops only, so it cannot glitch
  assign irq = |(status_q & mask_q);

endmodule

`default_nettype wire

//--- stepper_chk.sv
// port checker for the stepper phase sequencer
`timescale 1ns/1ps
`default_nettype none
module stepper_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic step_clk,
  input wire logic direction_select,
  input wire logic output_enable,
  input wire logic angle_reset,
  input wire logic step_res_sel_0,
  input wire logic step_res_sel_1,
  input wire logic step_res_sel_2,
  input wire logic overtemp_shutdown,
  input wire logic overcurrent_shutdown,
  input wire stepper_pkg::phase_drive_t phase_a_output,
  input wire stepper_pkg::phase_drive_t phase_b_output,
  input wire logic chopper_oscillator,
  input wire logic angle_home_monitor,
  input wire logic fault_flag_pin_oe_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  import stepper_pkg::*;
  // decoded pin groups
  wire [2:0] mode = {step_res_sel_0, step_res_sel_1, step_res_sel_2};
  wire flt = overtemp_shutdown | overcurrent_shutdown;
  wire fine = mode == MODE_QUARTER || mode > MODE_HALF_B;
  wire off = phase_a_output == '0 && phase_b_output == '0;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // two edges parked so index and outputs have both settled
  sequence s_home;
    (angle_reset && output_enable && !flt && fine)[*2];
  endsequence
  // no rise and no input change, so nothing may move
  sequence s_quiet;
    (!$rose(step_clk) && !angle_reset
      && $stable({direction_select, output_enable, mode, flt}))[*2];
  endsequence
  AST_OE_OFF: assert property (!output_enable |=> off)
    else $error("outputs on while disabled");
  AST_STANDBY: assert property (mode == MODE_STANDBY |=> off && !chopper_oscillator)
    else $error("standby not kept");
  AST_FLT_LOW: assert property (flt |=> !fault_flag_pin_oe_n)
    else $error("fault pin not low");
  AST_FLT_REL: assert property (!flt |=> fault_flag_pin_oe_n)
    else $error("fault pin not released");
  AST_HOME_MON: assert property (angle_reset |=> !angle_home_monitor)
    else $error("home monitor high in reset");
  AST_HOME_LVL: assert property (s_home |=> phase_a_output[7:0] == 8'hC7
    && phase_b_output[7:0] == 8'hC7) else $error("home level wrong");
  AST_HOLD: assert property (s_quiet |=> $stable(phase_a_output) && $stable(phase_b_output))
    else $error("outputs moved without a step");
  AST_RD_ZERO: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data without a read");
endmodule
bind stepper_phase_sequencer stepper_chk u_chk (.clk_sys, .rst_n, .step_clk, .direction_select,
  .output_enable, .angle_reset, .step_res_sel_0, .step_res_sel_1, .step_res_sel_2,
  .overtemp_shutdown, .overcurrent_shutdown, .phase_a_output, .phase_b_output,
  .chopper_oscillator, .angle_home_monitor, .fault_flag_pin_oe_n, .reg_rd, .reg_rdata);
`default_nettype wire

//--- host_model.sv
// host side: step pulse shaping and fault pin pull-up
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic step_go,
  input wire logic pin_o,
  input wire logic pin_oe_n,
  output logic step_clk,
  output wire logic pin_level
);
  // released pin is pulled up, never left floating
  assign pin_level = pin_oe_n ? 1'b1 : pin_o;
  // one cycle high, so a low cycle always separates rises
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      step_clk <= 1'b0;
    else
      step_clk <= step_go && !step_clk;
  end
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench for the stepper phase sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import stepper_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic step_go = 1'b0;
  logic dir = 1'b1;
  logic oe = 1'b1;
  logic hold = 1'b1;
  logic [2:0] mode = MODE_FULL;
  logic [1:0] flt = 2'b00;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  wire step_clk, pin_o, pin_oe_n, pin_level, osc, home_mon, irq;
  wire [31:0] rdata;
  phase_drive_t pa, pb;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] v;
  always #5 clk_sys = ~clk_sys;
  // hang guard, far above the roughly 180 cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  host_model u_host (.clk_sys, .rst_n, .step_go, .pin_o, .pin_oe_n, .step_clk, .pin_level);
  stepper_phase_sequencer uut (.clk_sys, .rst_n, .step_clk, .direction_select(dir),
    .output_enable(oe), .angle_reset(hold), .step_res_sel_0(mode[2]),
    .step_res_sel_1(mode[1]), .step_res_sel_2(mode[0]), .overtemp_shutdown(flt[0]),
    .overcurrent_shutdown(flt[1]), .phase_a_output(pa), .phase_b_output(pb),
    .chopper_oscillator(osc), .angle_home_monitor(home_mon), .fault_flag_pin_i(pin_level),
    .fault_flag_pin_o(pin_o), .fault_flag_pin_oe_n(pin_oe_n), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .irq);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_s <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // rise seen two edges on, outputs one edge after that
  task automatic step(input logic cw);
    @(posedge clk_sys);
    dir <= cw;
    step_go <= 1'b1;
    @(posedge clk_sys);
    step_go <= 1'b0;
    tick(3);
  endtask
  // park at home, drop the hold, change the mode there, park again
  task automatic set_mode(input logic [2:0] m);
    @(posedge clk_sys);
    hold <= 1'b1;
    repeat (2) @(posedge clk_sys);
    hold <= 1'b0;
    @(posedge clk_sys);
    mode <= m;
    @(posedge clk_sys);
    hold <= 1'b1;
  endtask
  task automatic t_home;
    logic [6:0] lvl;
    rd(ADDR_MASK);
    chk(v, 32'h0000_0000);
    for (int m = 1; m < 8; m++) begin
      lvl = (m == 3 || m > 4) ? 7'h47 : PCT_FULL;
      set_mode(3'(m));
      tick(3);
      chk(32'({pa, pb}), 32'({2'b11, lvl, 2'b11, lvl}));
      chk(32'(home_mon), 32'h0000_0000);
      rd(ADDR_POSITION);
      chk(32'({v[12], v[10:8], v[6:0]}), 32'({1'b1, 3'(m), ANGLE_HOME}));
    end
    set_mode(MODE_STANDBY);
    tick(3);
    chk(32'({osc, pa, pb}), 32'h0000_0000);
    $display("home test done");
  endtask
  task automatic t_step;
    set_mode(MODE_FULL);
    repeat (2) @(posedge clk_sys);
    hold <= 1'b0;
    step(1'b1);
    rd(ADDR_POSITION);
    chk(32'({v[6:0], pa.polarity, pb.polarity, home_mon}), 32'({7'h30, 3'b011}));
    chk(32'(osc), 32'h0000_0001);
    step(1'b0);
    step(1'b0);
    rd(ADDR_POSITION);
    chk(32'({v[6:0], pa.polarity, pb.polarity}), 32'({7'h70, 2'b10}));
    wr(ADDR_STATUS, 32'h0000_0007);
    wr(ADDR_MASK, 32'h0000_0004);
    set_mode(MODE_THIRTYSECOND);
    tick(2);
    chk(32'(irq), 32'h0000_0000);
    // a step while parked must leave the index at home
    step(1'b1);
    rd(ADDR_POSITION);
    chk(32'(v[6:0]), 32'(ANGLE_HOME));
    @(posedge clk_sys);
    hold <= 1'b0;
    step(1'b1);
    rd(ADDR_POSITION);
    chk(32'(v[6:0]), 32'h0000_0011);
    step(1'b0);
    chk(32'(irq), 32'h0000_0001);
    wr(ADDR_MASK, 32'h0000_0000);
    rd(ADDR_STATUS);
    chk(32'({v[2:0], irq}), 32'h0000_0008);
    wr(ADDR_STATUS, 32'h0000_0004);
    rd(ADDR_STATUS);
    chk(v, 32'h0000_0000);
    rd(8'h0c);
    chk(v, 32'h0000_0000);
    // the position word is read only
    wr(ADDR_POSITION, 32'h0000_007f);
    rd(ADDR_POSITION);
    chk(32'(v[6:0]), 32'(ANGLE_HOME));
    $display("step test done");
  endtask
  task automatic t_fault;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      flt <= 2'(k + 1);
      tick(2);
      chk(32'({pin_level, pa, pb}), 32'h0000_0000);
      rd(ADDR_STATUS);
      chk(32'(v[1:0]), 32'(k + 1));
      @(posedge clk_sys);
      flt <= 2'b00;
      tick(2);
      chk(32'({pin_level, pin_oe_n}), 32'h0000_0003);
      wr(ADDR_STATUS, 32'h0000_0003);
    end
    @(posedge clk_sys);
    oe <= 1'b0;
    tick(2);
    chk(32'({pa, pb}), 32'h0000_0000);
    $display("fault test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_home;
    t_step;
    t_fault;
    tally_and_finish;
  end
endmodule
`default_nettype wire
